//--- verilog/sps_startup_sequencer.sv
// Startup phase sequencer with APB control and status registers
`timescale 1ns/100ps
`include "sps_map.svh"

module sps_startup_sequencer
   import sps_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        lockIn,
   input  wire logic        matchIn,
   output sps_out_t         startOut
);

   sps_state_t state;
   sps_cfg_t   cfg;
   logic [2:0] phase;
   logic       pipeEn;
   logic       startReq;
   logic       doneRaw;
   logic       doneLate;
   logic       ioTristate;
   logic       writeEnable;
   logic       lockStall;
   logic       matchStall;
   logic       stall;
   logic       advance;
   logic       enter;
   logic [3:0] entryNum;
   logic [3:0] triEff;
   logic [3:0] wenEff;
   logic       apbSetup;
   logic       apbWr;
   logic       addrHit;
   logic       running;
   logic [31:0] statWord;

   // Bus decode; zero wait states, frozen with the clock enable
   assign apbSetup = psel & ~penable & ce;
   assign apbWr    = psel & penable & pwrite & ce;
   assign addrHit  = (paddr == `SPS_CTRL_OFS) | (paddr == `SPS_CFG_OFS) |
                     (paddr == `SPS_STAT_OFS);
   assign pready   = ce;
   assign pslverr  = psel & penable & ~addrHit;

   // Start request pulse, only meaningful while idle
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         startReq <= 1'b0;
      end else if (ce) begin
         startReq <= apbWr & (paddr == `SPS_CTRL_OFS) & pstrb[0] &
                     pwdata[`SPS_CTRL_START];
      end
   end

   // Pipeline option bit, may change at any time
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pipeEn <= 1'b0;
      end else if (apbWr && paddr == `SPS_CTRL_OFS && pstrb[0]) begin
         pipeEn <= pwdata[`SPS_CTRL_PIPE];
      end
   end

   // Phase selections; locked while running so a sequence stays coherent
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cfg <= `SPS_CFG_RESET;
      end else if (apbWr && paddr == `SPS_CFG_OFS && state == SPS_IDLE) begin
         if (pstrb[0]) begin
            cfg[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            cfg[15:8] <= pwdata[15:8];
         end
         if (pstrb[2]) begin
            cfg[19:16] <= pwdata[19:16];
         end
      end
   end

   // Stall terms; calibration length is outside our control
   assign running    = (state == SPS_RUN);
   assign lockStall  = running & (cfg.lockSel == {1'b0, phase}) &
                       ~lockIn;
   assign matchStall = running & (cfg.matchSel == {1'b0, phase}) &
                       ~matchIn;
   assign stall      = lockStall | matchStall;

   // Advance one phase per enabled cycle unless stalled
   assign advance  = ce & running & ~stall;
   assign enter    = (ce & (state == SPS_IDLE) & startReq) |
                     (advance & (phase != `SPS_LAST_PHASE));
   assign entryNum = (state == SPS_IDLE) ? 4'h0 : {1'b0, phase + 3'h1};

   // Done option maps onto the completion phase; keep never matches
   assign triEff = (cfg.triSel == `SPS_SEL_DONE) ? cfg.doneSel
                                                 : cfg.triSel;
   assign wenEff = (cfg.wenSel == `SPS_SEL_DONE) ? cfg.doneSel
                                                 : cfg.wenSel;

   // Sequencer state; one pass per reset
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state <= SPS_IDLE;
      end else if (ce) begin
         unique case (state)
            SPS_IDLE: begin
               if (startReq) begin
                  state <= SPS_RUN;
               end
            end
            SPS_RUN: begin
               if (advance && phase == `SPS_LAST_PHASE) begin
                  state <= SPS_FIN;
               end
            end
            SPS_FIN: begin
               state <= SPS_FIN;
            end
         endcase
      end
   end

   // Phase counter
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         phase <= 3'h0;
      end else if (enter) begin
         phase <= entryNum[2:0];
      end
   end

   // Completion flag set on entry to its phase
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         doneRaw <= 1'b0;
      end else if (enter && cfg.doneSel == entryNum) begin
         doneRaw <= 1'b1;
      end
   end

   // One extra stage for the pipelined completion output
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         doneLate <= 1'b0;
      end else if (ce) begin
         doneLate <= doneRaw;
      end
   end

   // I/O buffers stay tristated until the release phase
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ioTristate <= 1'b1;
      end else if (enter && triEff == entryNum) begin
         ioTristate <= 1'b0;
      end
   end

   // Global write enable; block RAM shares it so it cannot run early
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         writeEnable <= 1'b0;
      end else if (enter && wenEff == entryNum) begin
         writeEnable <= 1'b1;
      end
   end

   // Outputs; completion stays high so the source may stop clocking
   assign startOut.configDone  = pipeEn ? doneLate : doneRaw;
   assign startOut.ioTristate  = ioTristate;
   assign startOut.writeEnable = writeEnable;
   assign startOut.bramEnable  = writeEnable;

   // Status word assembly
   always_comb begin
      statWord = 32'h0000_0000;
      statWord[`SPS_STAT_PHASE +: 3] = phase;
      statWord[`SPS_STAT_RUN]        = running;
      statWord[`SPS_STAT_DONE]       = startOut.configDone;
      statWord[`SPS_STAT_TRI]        = ioTristate;
      statWord[`SPS_STAT_WEN]        = writeEnable;
      statWord[`SPS_STAT_LSTALL]     = lockStall;
      statWord[`SPS_STAT_MSTALL]     = matchStall;
      statWord[`SPS_STAT_FIN]        = (state == SPS_FIN);
   end

   // Read data captured in the setup cycle, stable through access
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (apbSetup && !pwrite) begin
         unique case (paddr)
            `SPS_CTRL_OFS: prdata <= {30'h0, pipeEn, 1'b0};
            `SPS_CFG_OFS:  prdata <= {12'h000, cfg};
            `SPS_STAT_OFS: prdata <= statWord;
            default:       prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Checks on the sequencing
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_doneEntry;
      enter && cfg.doneSel == entryNum && !doneRaw && !apbWr;
   endsequence

   sequence s_wenEntry;
      enter && wenEff == entryNum;
   endsequence

   a_done_entry: assert property (
      s_doneEntry ##0 !pipeEn |=> startOut.configDone)
      else $error("completion not raised on its phase");

   a_done_pipe: assert property (
      s_doneEntry ##0 pipeEn |=> doneRaw && !startOut.configDone)
      else $error("pipelined completion not delayed");

   a_tri_release: assert property (
      enter && triEff == entryNum |=> !startOut.ioTristate)
      else $error("tristate not released on its phase");

   // Next entered phase is at most phase+1, so only later selections hold
   a_tri_hold: assert property (
      running && ce && triEff > {1'b0, phase} + 4'h1 && triEff < 4'h7
      && ioTristate |=> startOut.ioTristate)
      else $error("tristate released early");

   a_wen_bram_on: assert property (
      s_wenEntry |=> startOut.writeEnable ##0 startOut.bramEnable)
      else $error("write or ram enable missing on its phase");

   a_bram_early: assert property (
      running && wenEff > {1'b0, phase} |-> !startOut.bramEnable)
      else $error("block ram enabled before write enable phase");

   a_lock_stall: assert property (
      lockStall && ce |=> $stable(phase) && running)
      else $error("sequencer moved despite lock stall");

   a_match_stall: assert property (
      matchStall && ce |=> $stable(phase) && running)
      else $error("sequencer moved despite match stall");

   a_step_one: assert property (
      advance && phase != `SPS_LAST_PHASE |=> phase == $past(phase) + 3'h1)
      else $error("phase did not step by one");

   a_keep_tri: assert property (
      triEff == `SPS_SEL_KEEP && startOut.ioTristate
      |=> startOut.ioTristate)
      else $error("kept tristate changed");

   a_keep_wen: assert property (
      wenEff == `SPS_SEL_KEEP && !startOut.writeEnable
      |=> !startOut.writeEnable)
      else $error("kept write enable changed");

endmodule : sps_startup_sequencer

//--- verilog/sps_map.svh
// Register offsets, field positions, reset values and codes of the sequencer
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH

// Byte offsets on the APB register bus
`define SPS_CTRL_OFS      12'h000
`define SPS_CFG_OFS       12'h004
`define SPS_STAT_OFS      12'h008

// Control register bits
`define SPS_CTRL_START    0
`define SPS_CTRL_PIPE     1

// Configuration register field positions, four bits each
`define SPS_CFG_DONE_LSB  0
`define SPS_CFG_TRI_LSB   4
`define SPS_CFG_WEN_LSB   8
`define SPS_CFG_LOCK_LSB  12
`define SPS_CFG_MATCH_LSB 16

// Reset value: match no-wait, lock no-wait, enable 6, release 5, done 4
`define SPS_CFG_RESET     20'hff654

// Selection codes beyond the plain phase numbers 0 to 6
`define SPS_SEL_DONE      4'he
`define SPS_SEL_KEEP      4'hf
`define SPS_SEL_SKIP      4'hf

// Last numbered phase before the sequence finishes
`define SPS_LAST_PHASE    3'h6

// Status register bit positions
`define SPS_STAT_PHASE    0
`define SPS_STAT_RUN      4
`define SPS_STAT_DONE     5
`define SPS_STAT_TRI      6
`define SPS_STAT_WEN      7
`define SPS_STAT_LSTALL   8
`define SPS_STAT_MSTALL   9
`define SPS_STAT_FIN      10

`endif

//--- verilog/sps_pkg.sv
// Types shared by the startup phase sequencer
package sps_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      SPS_IDLE,
      SPS_RUN,
      SPS_FIN
   } sps_state_t;

   // Phase selections held in the configuration register
   typedef struct packed {
      logic [3:0] matchSel;
      logic [3:0] lockSel;
      logic [3:0] wenSel;
      logic [3:0] triSel;
      logic [3:0] doneSel;
   } sps_cfg_t;

   // Global startup controls driven out to the fabric
   typedef struct packed {
      logic configDone;
      logic ioTristate;
      logic writeEnable;
      logic bramEnable;
   } sps_out_t;

endpackage : sps_pkg

//--- testbench/sps_cfg_source.sv
// Configuration source model feeding the sequencer clock enable
`timescale 1ns/100ps
module sps_cfg_source (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic slow,
   input  wire logic gapReq,
   input  wire logic configDone,
   output logic      ce
);
   // Gaps only when slow; never stops once completion is seen
   always_ff @(posedge mclk) begin
      if (!rstn)
         ce <= 1'b1;
      else
         ce <= !(slow && gapReq && !configDone);
   end

   // Producer choice of match phase: 2 with calibrated I/O
   function automatic logic [3:0] matchChoice(input logic calib);
      return calib ? 4'h2 : 4'hf;
   endfunction : matchChoice
endmodule : sps_cfg_source

//--- testbench/sps_startup_sequencer_test.sv
// Self-checking bench for the startup phase sequencer
`timescale 1ns/100ps
module sps_startup_sequencer_test;
   import sps_pkg::*;
   logic        mclk, rstn, psel, penable, pwrite, lockIn, matchIn;
   logic        slow, gapReq, ce, pready, pslverr, err, expDone;
   logic        mReq, mPipe, mDone, mDoneD, mTri, mWen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  mState;
   logic [2:0]  mPh;
   sps_out_t    startOut;
   sps_cfg_t    mCfg;
   int          num_errors, n_tests, seed;

   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end

   sps_startup_sequencer sps_startup_sequencer_inst (.mclk(mclk),
      .rstn(rstn), .ce(ce), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lockIn(lockIn), .matchIn(matchIn),
      .startOut(startOut));
   sps_cfg_source sps_cfg_source_inst (.mclk(mclk), .rstn(rstn),
      .slow(slow), .gapReq(gapReq), .configDone(startOut.configDone),
      .ce(ce));

   assign expDone = mPipe ? mDoneD : mDone;

   // Reference sequencer, stepping only on enabled edges
   always @(posedge mclk) begin : refModel
      logic [3:0] np;
      logic       go;
      if (!rstn) begin
         {mState, mPh, mReq, mPipe, mDone, mDoneD, mWen} <= '0;
         mCfg <= 20'hff654;
         mTri <= 1;
      end else if (ce) begin
         go = 0;
         np = {1'b0, mPh} + 4'h1;
         mDoneD <= mDone;
         if (psel && penable && pwrite && mState == 0) begin
            if (paddr == 12'h004) mCfg <= pwdata[19:0];
            if (paddr == 12'h000) {mPipe, mReq} <= pwdata[1:0];
         end
         if (mState == 0 && mReq) begin
            mState <= 1;
            np = 0;
            go = 1;
         end else if (mState == 1 &&
                      !(({1'b0, mPh} == mCfg.lockSel && !lockIn) ||
                        ({1'b0, mPh} == mCfg.matchSel && !matchIn))) begin
            if (mPh == 6) mState <= 2;
            else go = 1;
         end
         if (go) begin
            mPh <= np[2:0];
            if (mCfg.doneSel == np) mDone <= 1;
            if (mCfg.triSel == np ||
                (mCfg.triSel == 4'he && mCfg.doneSel == np)) mTri <= 0;
            if (mCfg.wenSel == np ||
                (mCfg.wenSel == 4'he && mCfg.doneSel == np)) mWen <= 1;
         end
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Outputs compared mid-cycle, once the edge has settled
   always @(negedge mclk) begin
      if (rstn === 1'b1)
         chk({28'h0, startOut}, {28'h0, expDone, mTri, mWen, mWen});
   end

   // One APB transfer; waits on pready, only the watchdog ends a hang
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge mclk);
      penable <= 1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb

   // Reset, configure, start, then steer lock and match inputs
   task automatic run(input sps_cfg_t c, input logic p, input int lh,
                      input int mh, input logic s);
      int k;
      {rstn, lockIn, matchIn, gapReq} <= 0;
      slow <= s;
      repeat (10) @(posedge mclk);
      rstn <= 1;
      apb(0, 12'h004, 0);
      chk(rd, 32'h000ff654);
      apb(0, 12'h008, 0);
      chk(rd, 32'h40);
      apb(0, 12'h00c, 0);
      chk({rd[30:0], err}, 1);
      apb(1, 12'h004, {12'h0, c});
      apb(1, 12'h000, {30'h0, p, 1'b1});
      for (k = 0; k < 300 && mState != 2; k++) begin
         lockIn <= k >= lh;
         matchIn <= k >= mh;
         gapReq <= 1'($random(seed));
         @(posedge mclk);
      end
      gapReq <= 0;
      chk(mState, 2);
      apb(0, 12'h000, 0);
      chk(rd, {30'h0, p, 1'b0});
      apb(1, 12'h004, {12'h0, ~c});
      apb(0, 12'h004, 0);
      chk(rd, {12'h0, c});
      apb(0, 12'h008, 0);
      chk(rd[10:5], {3'b100, mWen, mTri, expDone});
   endtask : run

   function automatic logic [3:0] pk(input logic [31:0] r);
      return (r % 9 == 8) ? 4'hf : (r % 9 == 7) ? 4'he : 4'(r % 9);
   endfunction : pk

   task automatic summarize();
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   // Corner runs first, then random selections
   initial begin : main
      sps_cfg_t c;
      logic [3:0] v;
      seed = 32'hbdcb7293;
      {rstn, psel, penable, pwrite, lockIn, matchIn, slow, gapReq} = 0;
      {paddr, pwdata, num_errors, n_tests} = 0;
      run(20'hff654, 0, 0, 0, 0);
      run(20'hff654, 1, 0, 0, 0);
      run(20'hf2654, 0, 15, 8, 1);
      c = {sps_cfg_source_inst.matchChoice(1'b1), 16'hffe1};
      run(c, 1, 0, 20, 1);
      repeat (8) begin
         c.doneSel = 4'h1 + 4'($unsigned($random(seed)) % 6);
         c.triSel = pk($random(seed));
         c.wenSel = pk($random(seed));
         v = pk($random(seed));
         c.lockSel = (v == 4'he) ? 4'hf : v;
         v = pk($random(seed));
         c.matchSel = (v == 4'he) ? 4'hf : v;
         run(c, 1'($random(seed)), $unsigned($random(seed)) % 30,
             $unsigned($random(seed)) % 30, 1'($random(seed)));
      end
      summarize();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #(20 * 30000);
      num_errors++;
      summarize();
   end
endmodule : sps_startup_sequencer_test
